// [hdl/iseq_top.sv]
`timescale 1ns/100ps
`default_nettype none
`include "iseq_defs.svh"
module iseq_top
   import iseq_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [`ISEQ_INSN_W-1:0] prog_data,
   input wire iseq_ctrl_t ctrl,
   input wire logic [7:0] result,
   input wire logic [7:0] status_wdata,
   input wire logic status_we,
   output logic [`ISEQ_PC_W-1:0] prog_addr,
   output logic [`ISEQ_INSN_W-1:0] instruction_holding_register,
   output logic phase_one,
   output logic phase_two,
   output logic phase_three,
   output logic phase_four,
   output iseq_dmem_t dmem,
   output logic [7:0] w_data,
   output logic w_load,
   output logic [7:0] status_reg,
   output logic flushing
);
   // ==========================================
   // Phase generator
   iseq_phase_t ph_ff, nxt_ph;
   always_comb begin
      nxt_ph = iseq_phase_t'(ph_ff + 2'h1); // RULE_01
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ph_ff <= ISEQ_PH1;
      end else begin
         ph_ff <= nxt_ph;
      end
   end
   assign phase_one = (ph_ff == ISEQ_PH1);
   assign phase_two = (ph_ff == ISEQ_PH2);
   assign phase_three = (ph_ff == ISEQ_PH3);
   assign phase_four = (ph_ff == ISEQ_PH4);

   // ==========================================
   // Program counter, pipeline, stack
   logic [`ISEQ_PC_W-1:0] pc_ff, nxt_pc;
   logic [`ISEQ_INSN_W-1:0] ir_ff, nxt_ir;
   logic [`ISEQ_STK_W-1:0] stk1_ff, nxt_stk1, stk2_ff, nxt_stk2;
   logic [7:0] status_ff, nxt_status, w_ff, nxt_w;
   logic flush_ff, nxt_flush, wload_ff, nxt_wload;
   logic branch;
   logic [`ISEQ_PC_W-1:0] target;
   // Controls are only honoured while a real instruction executes
   always_comb begin
      branch = !flush_ff && (ctrl.jump || ctrl.call || ctrl.ret || ctrl.pcl_write);
      target = pc_ff;
      if (ctrl.jump) begin
         target = {status_ff[`ISEQ_PAGE_BIT], ctrl.target}; // RULE_07 RULE_08
      end else if (ctrl.call) begin
         target = {status_ff[`ISEQ_PAGE_BIT], 1'b0, ctrl.target[7:0]}; // RULE_10
      end else if (ctrl.pcl_write) begin
         target = {status_ff[`ISEQ_PAGE_BIT], 1'b0, result}; // RULE_09 RULE_10
      end else if (ctrl.ret) begin
         target = stk1_ff[`ISEQ_PC_W-1:0]; // RULE_15
      end
   end
   always_comb begin
      nxt_pc = pc_ff;
      nxt_ir = ir_ff;
      nxt_stk1 = stk1_ff;
      nxt_stk2 = stk2_ff;
      nxt_status = status_ff;
      nxt_w = w_ff;
      nxt_flush = flush_ff;
      nxt_wload = 1'b0;
      // Held in a no-op cycle so the target (or reset vector) is fetched
      if (phase_one && !flush_ff) begin
         nxt_pc = pc_ff + 10'h001; // RULE_02 RULE_11
      end
      if (phase_four) begin
         nxt_ir = prog_data; // RULE_02 RULE_03 RULE_05
         nxt_flush = 1'b0;
         if (status_we && !flush_ff) begin
            nxt_status = status_wdata;
         end
         if (branch) begin
            nxt_pc = target; // RULE_04
            nxt_ir = `ISEQ_NOP; // RULE_19
            nxt_flush = 1'b1; // RULE_19
            if (ctrl.call) begin
               nxt_stk2 = stk1_ff; // RULE_14
               nxt_stk1 = {2'h0, pc_ff}; // RULE_13 RULE_14
            end else if (ctrl.ret) begin
               nxt_stk1 = stk2_ff; // RULE_15 RULE_18
               nxt_w = ctrl.literal; // RULE_16
               nxt_wload = 1'b1;
            end
         end
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pc_ff <= `ISEQ_PC_RESET; // RULE_11
         ir_ff <= `ISEQ_NOP;
         status_ff <= 8'h00; // RULE_12
         w_ff <= 8'h00;
         flush_ff <= 1'b1;
         wload_ff <= 1'b0;
      end else begin
         pc_ff <= nxt_pc;
         ir_ff <= nxt_ir;
         status_ff <= nxt_status;
         w_ff <= nxt_w;
         flush_ff <= nxt_flush;
         wload_ff <= nxt_wload;
      end
   end
   // Stack deliberately outside reset
   always_ff @(posedge clk) begin
      stk1_ff <= nxt_stk1; // RULE_17
      stk2_ff <= nxt_stk2; // RULE_17
   end

   // ==========================================
   // Outputs
   assign prog_addr = pc_ff;
   assign instruction_holding_register = ir_ff;
   // One driver for the whole carrier
   assign dmem = '{rd_en: phase_two && !flush_ff, wr_en: phase_four && !flush_ff, wdata: result}; // RULE_06
   assign w_data = w_ff;
   assign w_load = wload_ff;
   assign status_reg = status_ff;
   assign flushing = flush_ff;

   // ==========================================
   // Checks
   a_phase_order: assert property (@(posedge clk) disable iff (rst)
      phase_four |=> phase_one) else $error("phase order broken"); // RULE_01
   a_pc_inc: assert property (@(posedge clk) disable iff (rst)
      phase_one && !flush_ff |=> pc_ff == $past(pc_ff) + 10'h001) else $error("pc not incremented"); // RULE_02
   a_flush_hold: assert property (@(posedge clk) disable iff (rst)
      phase_one && flush_ff |=> pc_ff == $past(pc_ff)) else $error("pc moved in no-op"); // RULE_19
   a_flush_refuse: assert property (@(posedge clk) disable iff (rst)
      phase_four && flush_ff |=> status_ff == $past(status_ff) && !flush_ff) else $error("refuse"); // RULE_19
   a_read_phase: assert property (@(posedge clk) disable iff (rst)
      dmem.rd_en |-> phase_two) else $error("read phase"); // RULE_06
   a_wload_pulse: assert property (@(posedge clk) disable iff (rst)
      w_load |=> !w_load) else $error("w load not a pulse"); // RULE_16
   a_pcl_load: assert property (@(posedge clk) disable iff (rst)
      phase_four && branch && !ctrl.jump && !ctrl.call && ctrl.pcl_write
      |=> !pc_ff[8] && pc_ff[7:0] == $past(result)) else $error("pcl load"); // RULE_09
   a_flush_nop: assert property (@(posedge clk) disable iff (rst)
      phase_four && branch |=> ir_ff == `ISEQ_NOP && flush_ff) else $error("no flush"); // RULE_19
   a_call_push: assert property (@(posedge clk) disable iff (rst)
      phase_four && branch && ctrl.call |=> stk2_ff == $past(stk1_ff)) else $error("push bad"); // RULE_14
   a_ret_pop: assert property (@(posedge clk) disable iff (rst)
      phase_four && branch && !ctrl.jump && !ctrl.call && !ctrl.pcl_write && ctrl.ret
      |=> pc_ff == $past(stk1_ff[9:0]) && w_ff == $past(ctrl.literal)) else $error("pop bad"); // RULE_15
   a_jump_page: assert property (@(posedge clk) disable iff (rst)
      phase_four && branch && ctrl.jump |=> pc_ff[9] == $past(status_ff[5])) else $error("page"); // RULE_08
   a_call_bit8: assert property (@(posedge clk) disable iff (rst)
      phase_four && branch && !ctrl.jump && ctrl.call |=> !pc_ff[8]) else $error("bit8"); // RULE_10
   a_dmem_phase: assert property (@(posedge clk) disable iff (rst)
      dmem.wr_en |-> phase_four ##2 !dmem.wr_en) else $error("write phase"); // RULE_06
   c_call: cover property (@(posedge clk) phase_four && branch && ctrl.call);
   c_ret: cover property (@(posedge clk) phase_four && branch && ctrl.ret);
   c_jump: cover property (@(posedge clk) phase_four && branch && ctrl.jump);
   c_pcl: cover property (@(posedge clk) phase_four && branch && ctrl.pcl_write);
endmodule : iseq_top
`default_nettype wire

// [common/iseq_defs.svh]
// Behaviour
// [RULE_01] Divide oscillator by four into four phases
// [RULE_02] Increment PC at phase one, latch at four
// [RULE_03] Fetch next while executing current instruction
// [RULE_04] PC-changing instructions take two cycles
// [RULE_05] Present at phase one, execute phases two-four
// [RULE_06] Operand read phase two, write phase four
// [RULE_07] Absolute jump loads PC bits 8:0 from immediate
// [RULE_08] Status bit 5 supplies PC bit 9
// [RULE_09] Low PC latch maps onto PC 7:0
// [RULE_10] Call or latch write clears PC bit 8
// [RULE_11] Reset points PC at last location, then wraps
// [RULE_12] Reset clears page preselect bits
// [RULE_13] Two-level 12-bit return stack, no direct access
// [RULE_14] Call shifts level one down, pushes PC+1
// [RULE_15] Return pops level one, copies level two up
// [RULE_16] Return loads working register with literal
// [RULE_17] Reset leaves stack contents unchanged
// [RULE_18] No overflow or underflow indication
// [RULE_19] Taken branch flushes prefetch as no-op
`ifndef ISEQ_DEFS_SVH
`define ISEQ_DEFS_SVH
`define ISEQ_PC_W 10
`define ISEQ_INSN_W 12
`define ISEQ_STK_W 12
`define ISEQ_PC_RESET 10'h3ff
`define ISEQ_PAGE_BIT 5
`define ISEQ_NOP 12'h000
`define ISEQ_PH_LAST 2'h3
`endif

// [common/iseq_pkg.sv]
package iseq_pkg;
   typedef enum logic [1:0] {ISEQ_PH1, ISEQ_PH2, ISEQ_PH3, ISEQ_PH4} iseq_phase_t;
   // Decoded controls presented by the instruction decoder
   typedef struct packed {
      logic jump;
      logic call;
      logic ret;
      logic pcl_write;
      logic [8:0] target;
      logic [7:0] literal;
   } iseq_ctrl_t;
   typedef struct packed {
      logic rd_en;
      logic wr_en;
      logic [7:0] wdata;
   } iseq_dmem_t;
endpackage : iseq_pkg

// [dv/iseq_prog_mem.sv]
`timescale 1ns/100ps
`default_nettype none
// Program store: each word is a fold of its own address
module iseq_prog_mem (
   input wire logic [9:0] addr,
   output logic [11:0] data
);
   assign data = {addr[1:0], addr} ^ 12'h5a5;
endmodule : iseq_prog_mem
`default_nettype wire

// [dv/test_instruction_sequencer.sv]
`timescale 1ns/100ps
`default_nettype none
`include "iseq_defs.svh"
module test_instruction_sequencer import iseq_pkg::*;;
   logic clk = 0, rst = 1, status_we = 0, w_load, flushing;
   logic phase_one, phase_two, phase_three, phase_four;
   logic [11:0] prog_data, ir;
   logic [9:0] prog_addr, pa, p2, p3;
   logic [7:0] result = 8'h40, status_wdata = 8'h20, w_data, status_reg;
   iseq_ctrl_t ctrl = '0;
   iseq_dmem_t dmem;
   int n_errors = 0, num_checks = 0;
   always #2.5 clk = ~clk;
   iseq_prog_mem mem (.addr(prog_addr), .data(prog_data));
   iseq_top dut (.clk(clk), .rst(rst), .prog_data(prog_data), .ctrl(ctrl), .result(result),
      .status_wdata(status_wdata), .status_we(status_we), .prog_addr(prog_addr),
      .instruction_holding_register(ir), .phase_one(phase_one), .phase_two(phase_two),
      .phase_three(phase_three), .phase_four(phase_four), .dmem(dmem), .w_data(w_data),
      .w_load(w_load), .status_reg(status_reg), .flushing(flushing));
   // ==========================================
   // Shared tasks
   task check(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task wrap_up;
      $display("Checks %0d, errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : wrap_up
   // Flush cycles ignore controls, so only a live phase four takes one
   task to4;
      int i;
      for (i = 0; i < 12 && !(phase_four === 1'b1 && flushing === 1'b0); i++) @(posedge clk) #1;
      if (!(phase_four === 1'b1 && flushing === 1'b0)) begin
         n_errors++;
         wrap_up();
      end
   endtask : to4
   task issue(input logic [20:0] c);
      to4();
      pa = prog_addr;
      ctrl = c;
      @(posedge clk) #1;
      ctrl = '0;
   endtask : issue
   task do_reset;
      rst = 1;
      repeat (4) @(posedge clk);
      #1 rst = 0;
      check(prog_addr, 10'h3ff);
      check(status_reg, 8'h00);
      check({flushing, phase_one, ir}, 14'h3000);
   endtask : do_reset
   // ==========================================
   // Scenarios
   task t_flow;
      for (int k = 0; k < 8; k++) begin
         @(posedge clk) #1;
         check({phase_one, phase_two, phase_three, phase_four}, 4'h8 >> ((k + 1) % 4));
         if (k == 0) check({prog_addr, dmem.rd_en}, 11'h7fe);
         if (k == 3) check(ir, 12'ha5a);
         if (k == 4) check({prog_addr, dmem.rd_en}, 11'h001);
         if (k == 5) check({dmem.rd_en, dmem.wr_en}, 2'b00);
         if (k == 6) check({dmem.wr_en, dmem.wdata}, 9'h140);
      end
      $display("t_flow done");
   endtask : t_flow
   task t_jump;
      to4();
      status_we = 1;
      @(posedge clk) #1;
      status_we = 0;
      check(status_reg, 8'h20);
      issue({4'h8, 9'h155, 8'h00});
      check(prog_addr, 10'h355);
      check({flushing, ir}, 13'h1000);
      ctrl = {4'h8, 9'h0aa, 8'h00};
      repeat (4) @(posedge clk) #1;
      ctrl = '0;
      check(prog_addr, 10'h355);
      check(ir, 12'h2f0);
      issue({4'h1, 17'h0});
      check(prog_addr, 10'h240);
      $display("t_jump done");
   endtask : t_jump
   task t_stack;
      issue({4'h4, 9'h112, 8'h00});
      check(prog_addr, 10'h212);
      issue({4'h4, 9'h134, 8'h00});
      p2 = pa;
      issue({4'h4, 9'h156, 8'h00});
      p3 = pa;
      issue({4'h2, 9'h0, 8'h77});
      check(prog_addr, p3);
      check(w_load, 1'b1);
      @(posedge clk) #1;
      check(w_data, 8'h77);
      for (int k = 0; k < 2; k++) begin
         issue({4'h2, 9'h0, 8'h78});
         check(prog_addr, p2);
      end
      do_reset();
      issue({4'h2, 9'h0, 8'h79});
      check(prog_addr, p2);
      $display("t_stack done");
   endtask : t_stack
   initial begin
      #1 do_reset();
      t_flow();
      t_jump();
      t_stack();
      wrap_up();
   end
endmodule : test_instruction_sequencer
`default_nettype wire
